// ==== shared/bitm_defines.svh ====
// Address map, field positions and command codes of the interval timer
`ifndef BITM_DEFINES_SVH
`define BITM_DEFINES_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define BITM_ADDR_CNT0       8'h40
`define BITM_ADDR_CNT1       8'h41
`define BITM_ADDR_CNT2       8'h42
`define BITM_ADDR_CTRL       8'h43
`define BITM_ADDR_IRQ_STATUS 8'h44
`define BITM_ADDR_IRQ_CLEAR  8'h45
`define BITM_ADDR_IRQ_ENABLE 8'h46

// ****************************************************************
// Control byte fields
// ****************************************************************
`define BITM_CW_SEL          7:6
`define BITM_CW_RW           5:4
`define BITM_CW_MODE         3:1
`define BITM_CW_BCD          0
`define BITM_RB_NO_COUNT     5
`define BITM_RB_NO_STATUS    4
`define BITM_SEL_READBACK    2'h3

// ****************************************************************
// Byte access codes
// ****************************************************************
`define BITM_RW_LATCH        2'h0
`define BITM_RW_LSB          2'h1
`define BITM_RW_MSB          2'h2
`define BITM_RW_BOTH         2'h3

// ****************************************************************
// Reset values
// ****************************************************************
`define BITM_COUNT_RESET     16'h0000
`define BITM_BYTE_RESET      8'h00
`define BITM_IRQ_RESET       3'h0

`endif

// ==== shared/bitm_pkg.sv ====
// Types shared by the interval timer
package bitm_pkg;

    // ****************************************************************
    // Counter operating modes, in control byte order
    // ****************************************************************
    typedef enum logic [2:0] {
        bitm_mode_terminal,
        bitm_mode_oneshot,
        bitm_mode_rate,
        bitm_mode_square,
        bitm_mode_soft_strobe,
        bitm_mode_hard_strobe
    } bitm_mode_t;

endpackage

// ==== design/bitm_timer.sv ====
// Three-counter programmable interval timer with byte register port
//
// Contract
// R01 - Three independent 16-bit down counters, binary or BCD as programmed.
// R02 - One shared control logic reads, writes and configures all counters.
// R03 - Six modes per counter, numbered 0 to 5.
// R04 - All counters run from one shared count clock of 1.19318 MHz.
// R05 - Counter 0, gate always on, drives the system tick interrupt.
// R06 - Counter 1, gate always on, drives the refresh request.
// R07 - Counter 2 is gated by speaker enable and drives the tone.
// R08 - Each counter has control, status, count element, input and output latches.
// R09 - Output level follows programmed mode and count element state.
// R10 - Control address write loads control: counter, command, format.
// R11 - Status lets software watch a counter and read back its control.
// R12 - Count element loads from one or two data bytes per format.
// R13 - Count element loads or decrements on count clock falling edge.
// R14 - Loaded zero is maximum count; binary wraps zero to FFFFH.
// R15 - Counters read/write at own data addresses; control is write-only.
// R16 - Host writes control then initial count before trusting outputs.
// R17 - Control bits 7:4 counter/command, 3:1 mode, 0 BCD.
// R18 - Latched count holds until read or reprogram, then follows counter.
// R19 - Inactive gate holds the count in counting modes.
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps
`include "bitm_defines.svh"

module bitm_timer
    import bitm_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    // Register port
    input  wire logic [ADDR_WIDTH-1:0] addr,
    input  wire logic [7:0]            wdata,
    input  wire logic                  wr_en,
    input  wire logic                  rd_en,
    output logic      [7:0]            rdata,
    // Pins
    input  wire logic                  shared_count_clock,
    input  wire logic                  speaker_gate_enable,
    output wire logic                  tick_interrupt_out,
    output wire logic                  refresh_request,
    output wire logic                  speaker_tone,
    output wire logic                  timer_irq
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [15:0] dec1(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        logic        borrow;
        r      = v;
        borrow = 1'b1;
        if (!bcd) begin
            r = v - 16'h0001;
        end else begin
            for (int d = 0; d < 4; d++) begin
                if (borrow) begin
                    if (v[d*4 +: 4] == 4'h0) begin
                        r[d*4 +: 4] = 4'h9;
                    end else begin
                        r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
                        borrow      = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction

    function automatic bitm_mode_t norm_mode(input logic [2:0] m);
        logic [2:0] r;
        r = m[1] ? {1'b0, m[1:0]} : m;
        return bitm_mode_t'(r);
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic cclk_s1;
    logic cclk_s2;
    logic cclk_s3;
    logic spk_s1;
    logic spk_s2;
    logic tick;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cclk_s1 <= 1'b0;
            cclk_s2 <= 1'b0;
            cclk_s3 <= 1'b0;
        end else begin
            cclk_s1 <= shared_count_clock;
            cclk_s2 <= cclk_s1;
            cclk_s3 <= cclk_s2;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            spk_s1 <= 1'b0;
            spk_s2 <= 1'b0;
        end else begin
            spk_s1 <= speaker_gate_enable;
            spk_s2 <= spk_s1;
        end
    end

    // Falling edge of the shared count clock
    assign tick = cclk_s3 & ~cclk_s2; // see R04, R13

    // ****************************************************************
    // Shared command decode
    // ****************************************************************
    logic       ctrl_wr;
    logic       readback;
    logic [7:0] cnt_rbyte [3];
    wire  [2:0] cnt_out;
    wire  [2:0] cnt_event;

    assign ctrl_wr  = wr_en && (addr == `BITM_ADDR_CTRL); // see R10
    assign readback = (wdata[`BITM_CW_SEL] == `BITM_SEL_READBACK); // see R17

    // ****************************************************************
    // Counters
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : gen_cnt
            bitm_mode_t  mode;
            logic        bcd;
            logic [1:0]  rw;
            logic [15:0] cr;
            logic [7:0]  count_in_low_latch;
            logic        wr_hi;
            logic        load_pend;
            logic        trig_pend;
            logic        null_cnt;
            logic        fired;
            logic [15:0] ce;
            logic        out;
            logic        out_q;
            logic        gate;
            logic        gate_q;
            logic        cnt_latched;
            logic [15:0] ol;
            logic        st_latched;
            logic [7:0]  st;
            logic        rd_hi;
            logic        prog;
            logic        latch_cmd;
            logic        status_cmd;
            logic        data_wr;
            logic        data_rd;
            logic        new_count;
            logic [15:0] view;

            // Counters 0 and 1 always enabled, counter 2 by speaker enable
            assign gate = (i == 2) ? spk_s2 : 1'b1; // see R05, R06, R07

            // One decode path serves every counter
            assign prog       = ctrl_wr && !readback && (wdata[`BITM_CW_SEL] == i)
                                && (wdata[`BITM_CW_RW] != `BITM_RW_LATCH); // see R02, R10
            assign latch_cmd  = ctrl_wr && (readback
                                ? (!wdata[`BITM_RB_NO_COUNT] && wdata[i+1])
                                : ((wdata[`BITM_CW_SEL] == i)
                                   && (wdata[`BITM_CW_RW] == `BITM_RW_LATCH)));
            assign status_cmd = ctrl_wr && readback && !wdata[`BITM_RB_NO_STATUS]
                                && wdata[i+1]; // see R11
            assign data_wr    = wr_en && (addr == (`BITM_ADDR_CNT0 + i)); // see R15
            assign data_rd    = rd_en && (addr == (`BITM_ADDR_CNT0 + i)); // see R15
            assign new_count  = data_wr && ((rw != `BITM_RW_BOTH) || wr_hi); // see R12

            // Control register
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    mode <= bitm_mode_terminal;
                    bcd  <= 1'b0;
                    rw   <= `BITM_RW_BOTH;
                end else if (prog) begin
                    mode <= norm_mode(wdata[`BITM_CW_MODE]); // see R03, R17
                    bcd  <= wdata[`BITM_CW_BCD]; // see R01
                    rw   <= wdata[`BITM_CW_RW];
                end
            end

            // Input latches
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    cr                 <= `BITM_COUNT_RESET;
                    count_in_low_latch <= `BITM_BYTE_RESET;
                    wr_hi              <= 1'b0;
                end else if (prog) begin
                    wr_hi <= 1'b0;
                end else if (data_wr) begin
                    case (rw)
                        `BITM_RW_LSB: begin
                            cr <= {8'h00, wdata}; // see R12
                        end
                        `BITM_RW_MSB: begin
                            cr <= {wdata, 8'h00}; // see R12
                        end
                        default: begin
                            if (!wr_hi) begin
                                count_in_low_latch <= wdata;
                                wr_hi              <= 1'b1;
                            end else begin
                                cr    <= {wdata, count_in_low_latch}; // see R08, R12
                                wr_hi <= 1'b0;
                            end
                        end
                    endcase
                end
            end

            // Gate and output edge detect
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    gate_q <= 1'b0;
                    out_q  <= 1'b0;
                end else begin
                    gate_q <= gate;
                    out_q  <= out;
                end
            end

            // Counting element and output
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    ce        <= `BITM_COUNT_RESET;
                    out       <= 1'b0;
                    load_pend <= 1'b0;
                    trig_pend <= 1'b0;
                    null_cnt  <= 1'b1;
                    fired     <= 1'b0;
                end else if (prog) begin
                    load_pend <= 1'b0;
                    trig_pend <= 1'b0;
                    null_cnt  <= 1'b1;
                    fired     <= 1'b0;
                    out       <= (norm_mode(wdata[`BITM_CW_MODE]) != bitm_mode_terminal);
                end else begin
                    if (tick) begin // see R13
                        case (mode)
                            bitm_mode_oneshot, bitm_mode_hard_strobe: begin
                                if (trig_pend) begin
                                    ce        <= cr;
                                    trig_pend <= 1'b0;
                                    load_pend <= 1'b0;
                                    null_cnt  <= 1'b0;
                                    fired     <= 1'b0;
                                    out       <= (mode != bitm_mode_oneshot);
                                end else begin
                                    ce <= dec1(ce, bcd); // see R14
                                    if (ce == 16'h0001 && !fired) begin
                                        fired <= 1'b1;
                                        out   <= (mode == bitm_mode_oneshot); // see R09
                                    end else if (mode == bitm_mode_hard_strobe) begin
                                        out <= 1'b1;
                                    end
                                end
                            end
                            default: begin
                                if (load_pend) begin
                                    ce        <= (mode == bitm_mode_square)
                                                 ? {cr[15:1], 1'b0} : cr; // see R14
                                    load_pend <= 1'b0;
                                    null_cnt  <= 1'b0;
                                    fired     <= 1'b0;
                                    out       <= (mode != bitm_mode_terminal);
                                end else if (!gate) begin
                                    // Count holds; rate and square force high
                                    if (mode == bitm_mode_rate || mode == bitm_mode_square) begin
                                        out <= 1'b1; // see R19
                                    end
                                end else begin
                                    case (mode)
                                        bitm_mode_rate: begin
                                            if (ce == 16'h0001) begin
                                                ce  <= cr;
                                                out <= 1'b1;
                                            end else begin
                                                ce  <= dec1(ce, bcd);
                                                out <= (ce != 16'h0002); // see R09
                                            end
                                        end
                                        bitm_mode_square: begin
                                            if (ce == 16'h0002) begin
                                                ce  <= {cr[15:1], 1'b0};
                                                out <= ~out; // see R09
                                            end else begin
                                                ce <= dec1(dec1(ce, bcd), bcd);
                                            end
                                        end
                                        bitm_mode_soft_strobe: begin
                                            ce <= dec1(ce, bcd);
                                            if (ce == 16'h0001 && !fired) begin
                                                fired <= 1'b1;
                                                out   <= 1'b0; // see R09
                                            end else begin
                                                out <= 1'b1;
                                            end
                                        end
                                        default: begin
                                            ce <= dec1(ce, bcd); // see R14
                                            if (ce == 16'h0001) begin
                                                out <= 1'b1; // see R09
                                            end
                                        end
                                    endcase
                                end
                            end
                        endcase
                    end
                    if (new_count) begin
                        load_pend <= 1'b1;
                        null_cnt  <= 1'b1;
                        if (mode == bitm_mode_terminal) begin
                            out <= 1'b0;
                        end
                    end
                    if (gate && !gate_q) begin
                        trig_pend <= 1'b1;
                    end
                end
            end

            // Output latches and status latch
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    ol          <= `BITM_COUNT_RESET;
                    cnt_latched <= 1'b0;
                    st          <= `BITM_BYTE_RESET;
                    st_latched  <= 1'b0;
                    rd_hi       <= 1'b0;
                end else if (prog) begin
                    cnt_latched <= 1'b0; // see R18
                    st_latched  <= 1'b0;
                    rd_hi       <= 1'b0;
                end else begin
                    if (data_rd) begin
                        if (st_latched) begin
                            st_latched <= 1'b0;
                        end else if (rw != `BITM_RW_BOTH || rd_hi) begin
                            cnt_latched <= 1'b0; // see R18
                            rd_hi       <= 1'b0;
                        end else begin
                            rd_hi <= 1'b1;
                        end
                    end
                    if (latch_cmd && !cnt_latched) begin
                        ol          <= ce; // see R18
                        cnt_latched <= 1'b1;
                    end
                    if (status_cmd && !st_latched) begin
                        st         <= {out, null_cnt, rw, mode, bcd}; // see R11
                        st_latched <= 1'b1;
                    end
                end
            end

            // Byte presented on a data read
            assign view         = cnt_latched ? ol : ce;
            assign cnt_rbyte[i] = st_latched ? st
                                  : ((rw == `BITM_RW_MSB) || (rw == `BITM_RW_BOTH && rd_hi))
                                  ? view[15:8] : view[7:0];
            assign cnt_out[i]   = out;
            assign cnt_event[i] = out & ~out_q;
        end
    endgenerate

    assign tick_interrupt_out = cnt_out[0]; // see R05
    assign refresh_request    = cnt_out[1]; // see R06
    assign speaker_tone       = cnt_out[2]; // see R07

    // ****************************************************************
    // Interrupt status, clear and enable
    // ****************************************************************
    logic [2:0] irq_status;
    logic [2:0] irq_enable;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= `BITM_IRQ_RESET;
        end else if (wr_en && addr == `BITM_ADDR_IRQ_CLEAR) begin
            irq_status <= (irq_status & ~wdata[2:0]) | cnt_event;
        end else begin
            irq_status <= irq_status | cnt_event;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_enable <= `BITM_IRQ_RESET;
        end else if (wr_en && addr == `BITM_ADDR_IRQ_ENABLE) begin
            irq_enable <= wdata[2:0];
        end
    end

    assign timer_irq = |(irq_status & irq_enable);

    // ****************************************************************
    // Read data
    // ****************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= `BITM_BYTE_RESET;
        end else if (rd_en) begin
            if (addr == `BITM_ADDR_CNT0) begin
                rdata <= cnt_rbyte[0]; // see R15
            end else if (addr == `BITM_ADDR_CNT1) begin
                rdata <= cnt_rbyte[1];
            end else if (addr == `BITM_ADDR_CNT2) begin
                rdata <= cnt_rbyte[2];
            end else if (addr == `BITM_ADDR_IRQ_STATUS) begin
                rdata <= {5'h00, irq_status};
            end else if (addr == `BITM_ADDR_IRQ_ENABLE) begin
                rdata <= {5'h00, irq_enable};
            end else begin
                rdata <= `BITM_BYTE_RESET; // control is write-only, see R15
            end
        end else begin
            rdata <= `BITM_BYTE_RESET;
        end
    end

endmodule

// ==== tb/bitm_count_src.sv ====
// Free running count clock source for the timer
`timescale 1ns/1ps
module bitm_count_src #(
    parameter real HALF = 419.0
) (
    // Count clock
    output logic cnt_clk
);
    initial cnt_clk = 1'b1;
    always #(HALF) cnt_clk = ~cnt_clk;
endmodule

// ==== tb/bitm_timer_props.sv ====
// Port level checks of the interval timer
`timescale 1ns/1ps
module bitm_timer_props
    import bitm_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    // Clock, reset, register port
    input wire logic                  clock,
    input wire logic                  rst_n,
    input wire logic [ADDR_WIDTH-1:0] addr,
    input wire logic [7:0]            wdata,
    input wire logic                  wr_en,
    input wire logic                  rd_en,
    input wire logic [7:0]            rdata,
    // Pins
    input wire logic                  shared_count_clock,
    input wire logic                  tick_interrupt_out,
    input wire logic                  refresh_request,
    input wire logic                  timer_irq
);
    logic [2:0] en;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            en <= 3'h0;
        else if (wr_en && addr == 8'h46)
            en <= wdata[2:0];
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
        else $error("read data not zero when idle");
    a_ctrl_wo: assert property (rd_en && addr == 8'h43 |=> rdata == 8'h00)
        else $error("control read not zero");
    a_unmapped_zero: assert property (rd_en && addr > 8'h46 |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_status_width: assert property (rd_en && addr == 8'h44 |=> rdata[7:3] == 5'h00)
        else $error("status upper bits set");
    a_enable_back: assert property (rd_en && addr == 8'h46 |=> rdata == {5'h00, $past(en)})
        else $error("enable read back wrong");
    a_irq_mask: assert property (en == 3'h0 |-> !timer_irq)
        else $error("interrupt while all masked");
    a_irq_tick: assert property ($rose(tick_interrupt_out) && en[0] && !wr_en |=> timer_irq)
        else $error("tick did not raise interrupt");
    a_tick_edge: assert property ($changed(refresh_request)
        |-> !shared_count_clock || $past(wr_en) || $past(wr_en, 2))
        else $error("refresh output moved off count edge");
endmodule

bind bitm_timer bitm_timer_props #(.ADDR_WIDTH(ADDR_WIDTH)) i_props (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .shared_count_clock(shared_count_clock),
    .tick_interrupt_out(tick_interrupt_out), .refresh_request(refresh_request),
    .timer_irq(timer_irq));

// ==== tb/tb_top.sv ====
// Self-checking bench of the interval timer
`timescale 1ns/1ps
module tb_top;
    logic       clock = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, gate = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
    logic       cnt_clk, tick, refresh, tone, irq;
    int         error_cnt = 0, comparisons = 0, n;
    always #25 clock = ~clock;
    bitm_count_src i_src (.cnt_clk(cnt_clk));
    bitm_timer i_dut (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .shared_count_clock(cnt_clk),
        .speaker_gate_enable(gate), .tick_interrupt_out(tick), .refresh_request(refresh),
        .speaker_tone(tone), .timer_irq(irq));
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ticks(input int k);
        repeat (k) @(negedge cnt_clk);
        repeat (6) @(posedge clock);
    endtask
    task automatic tick_rise(input logic sel);
        n = 0;
        while ((sel ? refresh : tick) !== 1'b0 && n < 900) begin
            @(negedge clock);
            n++;
        end
        while ((sel ? refresh : tick) !== 1'b1 && n < 900) begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic final_report;
        $display("Checks %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        #500us;
        error_cnt++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        rd(8'h44); check("irq status", d, 8'h00);
        rd(8'h46); check("irq enable", d, 8'h00);
        rd(8'h43); check("control", d, 8'h00);
        rd(8'h47); check("unmapped", d, 8'h00);
        $display("Test reset done");
        wr(8'h43, 8'hB0);
        wr(8'h42, 8'h34);
        wr(8'h42, 8'h12);
        ticks(4);
        wr(8'h43, 8'h80);
        gate <= 1'b1;
        ticks(2);
        rd(8'h42); check("latched low", d, 8'h34);
        rd(8'h42); check("latched high", d, 8'h12);
        wr(8'h43, 8'hE8);
        rd(8'h42); check("status byte", d, 8'h30);
        check("tone low", {7'h00, tone}, 8'h00);
        wr(8'h42, 8'h00);
        wr(8'h42, 8'h00);
        ticks(4);
        wr(8'h43, 8'h80);
        rd(8'h42);
        rd(8'h42); check("wrapped high", d, 8'hFF);
        wr(8'h43, 8'hB1);
        wr(8'h42, 8'h00);
        wr(8'h42, 8'h00);
        ticks(4);
        wr(8'h43, 8'h80);
        rd(8'h42);
        rd(8'h42); check("bcd high", d, 8'h99);
        $display("Test counter 2 done");
        wr(8'h43, 8'h14);
        wr(8'h40, 8'h05);
        wr(8'h43, 8'h56);
        wr(8'h41, 8'h04);
        tick_rise(1'b0);
        tick_rise(1'b0);
        check("tick period", {7'h00, n > 82 && n < 86}, 8'h01);
        tick_rise(1'b1);
        tick_rise(1'b1);
        check("refresh period", {7'h00, n > 65 && n < 69}, 8'h01);
        rd(8'h44); check("status bits", d & 8'h03, 8'h03);
        check("irq masked", {7'h00, irq}, 8'h00);
        wr(8'h46, 8'h01);
        #1 check("irq on", {7'h00, irq}, 8'h01);
        wr(8'h45, 8'h07);
        rd(8'h44); check("status cleared", d & 8'h01, 8'h00);
        tick_rise(1'b0);
        repeat (2) @(negedge clock);
        check("irq again", {7'h00, irq}, 8'h01);
        $display("Test tick and irq done");
        final_report();
    end
endmodule
